/* include/swl_pkg.sv */
// Purpose: constants for the single-wire wake and bit timing block
// Assumes: 250 MHz mclk (4 ns period)
// Notes: times kept in their own unit, cycle counts derived from them
package swl_pkg;
    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    // ------------------------------------------------------------
    // times, each in its own unit
    // ------------------------------------------------------------
    localparam int GLITCH_ACTIVE_NS = 45;
    localparam int SLEEP_GLITCH_US = 15;
    localparam int WAKE_LOW_US = 60;
    localparam int WATCHDOG_MS = 1300;
    localparam int INACTIVE_MS = 65;
    localparam int TURNAROUND_US = 96;
    localparam int TX_PULSE_NS = 6000;
    localparam int TX_BIT_NS = 54000;
    // ------------------------------------------------------------
    // derived cycle counts (least times rounded up)
    // ------------------------------------------------------------
    localparam int GLITCH_ACTIVE_CYC =
        (GLITCH_ACTIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SLEEP_GLITCH_CYC =
        (SLEEP_GLITCH_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TURNAROUND_CYC = TURNAROUND_US * 1000000 / CLK_PERIOD_PS;
    localparam int TX_PULSE_CYC = TX_PULSE_NS * 1000 / CLK_PERIOD_PS;
    localparam int TX_BIT_CYC = TX_BIT_NS * 1000 / CLK_PERIOD_PS;
    localparam int WAKE_LOW_CYC = WAKE_LOW_US * 1000000 / CLK_PERIOD_PS;
    // long counts, used as parameter defaults
    localparam longint WATCHDOG_CYC =
        longint'(WATCHDOG_MS) * 64'd1000000000 / CLK_PERIOD_PS;
    localparam longint INACTIVE_CYC =
        longint'(INACTIVE_MS) * 64'd1000000000 / CLK_PERIOD_PS;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CNT_W = 32;
    localparam int DATA_W = 7;
endpackage : swl_pkg

/* design/swl_glitch_filter.sv */
// Purpose: pin synchroniser plus pulse-width filter for the data line
// Assumes: line idles high; filter width given in cycles
// Notes: output changes only after the level holds for width cycles
`timescale 1ns/100ps
module swl_glitch_filter
    import swl_pkg::*;
#(
    parameter int ACT_W = GLITCH_ACTIVE_CYC,
    parameter int SLP_W = SLEEP_GLITCH_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // line and mode
    input wire logic lineIn,
    input wire logic asleep,
    // filtered line
    output logic lineOut
);
    initial begin
        if (ACT_W < 1 || SLP_W < ACT_W)
            $error("swl_glitch_filter: bad filter widths");
    end

    typedef struct packed {
        logic [2:0] sync;
        logic level;
        logic [CNT_W-1:0] cnt;
    } swl_flt_t;

    swl_flt_t cur;
    swl_flt_t next_cur;

    // ------------------------------------------------------------
    // filter
    // ------------------------------------------------------------
    // asleep: only low pulses use the long width; highs use short width
    always_comb begin
        logic [CNT_W-1:0] width;
        width = CNT_W'(ACT_W);
        next_cur = cur;
        next_cur.sync = {cur.sync[1:0], lineIn};
        if (asleep && cur.level)
            width = CNT_W'(SLP_W);
        if (cur.sync[2] != cur.sync[1] || cur.sync[2] == cur.level) begin
            next_cur.cnt = '0;
        end else if (cur.cnt + 1'b1 >= width) begin
            next_cur.level = cur.sync[2];
            next_cur.cnt = '0;
        end else begin
            next_cur.cnt = cur.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{sync: 3'h7, level: 1'b1, cnt: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign lineOut = cur.level;

    // short active pulses never move the filtered level
    a_glitch_hold: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $changed(cur.level) |-> $past(cur.sync[2]) == cur.level &&
        $past(cur.cnt) + 1 >= CNT_W'(ACT_W))
        else $error("filter level changed before width was met");
    // a wake low needs the long width while asleep
    a_sleep_width: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $fell(cur.level) && $past(asleep) |->
        $past(cur.cnt) + 1 >= CNT_W'(SLP_W))
        else $error("short low pulse passed while asleep");
endmodule : swl_glitch_filter

/* design/swl_link.sv */
// Purpose: device end of the single-wire link: wake, sleep, rx, tx timing
// Assumes: open-drain data line, 250 MHz mclk, host keeps its timing
// Notes: rx bits decoded from pulse count per bit window
// Contract
// - ignore active pulses under 45 ns
// - ignore sleep low pulses under 15 us
// - watchdog forces sleep after wake
// - timing matches 230.4 kbaud uart (code uses 6 us pulses and 54 us bits)
// - reply starts 64 to 131 us after
// - sleep after line inactive too long
`timescale 1ns/100ps
module swl_link
    import swl_pkg::*;
#(
    parameter longint WDOG_CYC = WATCHDOG_CYC,
    parameter longint IDLE_CYC = INACTIVE_CYC,
    parameter int TURN_CYC = TURNAROUND_CYC,
    parameter int PULSE_CYC = TX_PULSE_CYC,
    parameter int BIT_CYC = TX_BIT_CYC,
    parameter int WAKE_CYC = WAKE_LOW_CYC,
    parameter int SLP_FLT_CYC = SLEEP_GLITCH_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // data line, open drain
    input wire logic lineIn,
    output logic lineOut,
    output logic lineOe,
    // received bits
    output logic rxValid,
    output logic rxBit,
    // bits to send after the turnaround
    input wire logic txReq,
    input wire logic txBit,
    input wire logic txLast,
    output logic txTaken,
    // status
    output logic awake,
    output logic busy
);
    // refuse counts that the counters and the sequence cannot serve
    initial begin
        if (WDOG_CYC < 2 || IDLE_CYC < 2 || PULSE_CYC < 1 ||
            BIT_CYC < 4 * PULSE_CYC || TURN_CYC <= BIT_CYC / 2 ||
            WAKE_CYC < 1 || WDOG_CYC >= (longint'(1) << CNT_W) ||
            IDLE_CYC >= (longint'(1) << CNT_W))
            $error("swl_link: bad timing parameters");
    end

    typedef enum logic [2:0] {
        S_SLEEP, S_WAKE, S_IDLE, S_RXBIT, S_TURN, S_TXBIT
    } swl_state_t;

    typedef struct packed {
        swl_state_t st;
        logic [CNT_W-1:0] wdog;
        logic [CNT_W-1:0] idle;
        logic [CNT_W-1:0] t;
        logic [1:0] falls;
        logic prevLine;
        logic zero;
        logic last;
        logic drive;
        logic rxValid;
        logic rxBit;
        logic txTaken;
        logic awake;
        logic busy;
    } swl_core_t;

    swl_core_t cur;
    swl_core_t next_cur;
    logic line;

    // ------------------------------------------------------------
    // input filter and synchroniser
    // ------------------------------------------------------------
    swl_glitch_filter #(
        .ACT_W(GLITCH_ACTIVE_CYC),
        .SLP_W(SLP_FLT_CYC)
    ) u_filter (
        .mclk(mclk),
        .rst_n(rst_n),
        .lineIn(lineIn),
        .asleep(cur.st == S_SLEEP),
        .lineOut(line)
    );

    function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
        return v + 1'b1;
    endfunction : inc

    // ------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic fell;
        fell = cur.prevLine && !line;
        next_cur = cur;
        next_cur.prevLine = line;
        next_cur.rxValid = 1'b0;
        next_cur.txTaken = 1'b0;
        next_cur.t = inc(cur.t);
        next_cur.wdog = inc(cur.wdog);
        next_cur.idle = (fell || cur.drive) ? '0 : inc(cur.idle);
        case (cur.st)
            S_SLEEP: begin
                next_cur.wdog = '0;
                next_cur.idle = '0; // inactivity counts from wake
                next_cur.drive = 1'b0;
                next_cur.t = line ? '0 : inc(cur.t);
                if (!line && cur.t + 1 >= CNT_W'(WAKE_CYC))
                    next_cur.st = S_WAKE;
            end
            S_WAKE: begin
                if (line) begin
                    next_cur.st = S_IDLE;
                    next_cur.idle = '0;
                end
            end
            S_IDLE: begin
                if (fell) begin
                    next_cur.st = S_RXBIT;
                    next_cur.t = '0;
                    next_cur.falls = '0;
                end
            end
            S_RXBIT: begin
                // a zero shows a second falling edge inside the bit
                if (fell && cur.falls != 2'h3)
                    next_cur.falls = cur.falls + 2'h1;
                if (cur.t + 1 >= CNT_W'(BIT_CYC / 2)) begin
                    next_cur.rxValid = 1'b1;
                    next_cur.rxBit = (cur.falls == 2'h0);
                    next_cur.st = txReq ? S_TURN : S_IDLE;
                end
            end
            S_TURN: begin
                // measured from the last bit's start edge
                if (cur.t + 1 >= CNT_W'(TURN_CYC)) begin
                    next_cur.t = '0;
                    if (txReq) begin
                        next_cur.st = S_TXBIT;
                        next_cur.zero = !txBit;
                        next_cur.last = txLast;
                        next_cur.txTaken = 1'b1;
                        next_cur.drive = 1'b1;
                    end else begin
                        next_cur.st = S_IDLE;
                    end
                end
            end
            S_TXBIT: begin
                // start low, high gap, zero low, then release
                next_cur.drive = (cur.t + 1 < CNT_W'(PULSE_CYC)) ||
                    (cur.zero && cur.t + 1 >= CNT_W'(2 * PULSE_CYC) &&
                    cur.t + 1 < CNT_W'(3 * PULSE_CYC));
                if (cur.t + 1 >= CNT_W'(BIT_CYC)) begin
                    next_cur.t = '0;
                    if (!cur.last && txReq) begin
                        next_cur.zero = !txBit;
                        next_cur.last = txLast;
                        next_cur.txTaken = 1'b1;
                        next_cur.drive = 1'b1;
                    end else begin
                        next_cur.st = S_IDLE;
                        next_cur.drive = 1'b0;
                    end
                end
            end
            default: next_cur.st = S_SLEEP;
        endcase
        // sleep forcing by watchdog or inactivity, either one overrides the sequencer
        if (cur.st != S_SLEEP && (cur.wdog + 1 >= CNT_W'(WDOG_CYC) ||
            cur.idle + 1 >= CNT_W'(IDLE_CYC))) begin
            next_cur.st = S_SLEEP;
            next_cur.drive = 1'b0;
            next_cur.t = '0;
        end
        // status flags registered from the next state
        next_cur.awake = (next_cur.st != S_SLEEP);
        next_cur.busy = (next_cur.st == S_TURN) || (next_cur.st == S_TXBIT);
    end

    // state register

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{st: S_SLEEP, prevLine: 1'b1, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // outputs, straight from state
    // ------------------------------------------------------------
    assign lineOut = 1'b0;
    assign lineOe = cur.drive;
    assign rxValid = cur.rxValid;
    assign rxBit = cur.rxBit;
    assign txTaken = cur.txTaken;
    assign awake = cur.awake;
    assign busy = cur.busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_wdog_sleep: assert property (@(posedge mclk)
        disable iff (!rst_n)
        cur.wdog >= CNT_W'(WDOG_CYC) |-> cur.st == S_SLEEP)
        else $error("watchdog did not force sleep");
    a_idle_sleep: assert property (@(posedge mclk)
        disable iff (!rst_n)
        cur.idle >= CNT_W'(IDLE_CYC) |-> cur.st == S_SLEEP)
        else $error("inactivity did not force sleep");
    a_no_drive_sleep: assert property (@(posedge mclk)
        disable iff (!rst_n)
        cur.st == S_SLEEP |-> !lineOe)
        else $error("line driven while asleep");
    a_turn_first: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $rose(lineOe) && $past(cur.st) == S_TURN |->
        $past(cur.t) + 1 >= CNT_W'(TURN_CYC))
        else $error("reply began before turnaround");
    a_start_width: assert property (@(posedge mclk)
        disable iff (!rst_n)
        cur.st == S_TXBIT && cur.t < CNT_W'(PULSE_CYC) |-> lineOe)
        else $error("start pulse too short");
    a_one_pair: assert property (@(posedge mclk)
        disable iff (!rst_n)
        cur.st == S_TXBIT && !cur.zero && cur.t >= CNT_W'(PULSE_CYC)
        |-> !lineOe)
        else $error("one bit carries extra pulse");
    a_rx_once: assert property (@(posedge mclk)
        disable iff (!rst_n)
        rxValid |=> !rxValid)
        else $error("bit reported twice");
    a_wake_entry: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $past(cur.st) == S_SLEEP && cur.st == S_WAKE |->
        $past(cur.t) + 1 >= CNT_W'(WAKE_CYC))
        else $error("woke without long low pulse");

    c_wake: cover property (@(posedge mclk) cur.st == S_WAKE);
    c_rx_zero: cover property (@(posedge mclk) rxValid && !rxBit);
    c_tx: cover property (@(posedge mclk) txTaken);
    c_sleep: cover property (@(posedge mclk) $fell(awake));
endmodule : swl_link

/* dv/swl_host_model.sv */
// Purpose: host model driving the single data line of the link
// Assumes: line pulled up; low while either party pulls it
// Notes: widths in mclk cycles, scaled down with the device counts
`timescale 1ns/100ps
module swl_host_model (
    // clock
    input wire logic mclk,
    // device pull-down
    input wire logic lineOe,
    // resolved line level
    output logic line
);
    logic hostLow = 1'b0;
    // ------------------------------------------------------------
    // open drain with pull-up: a released line reads high
    // ------------------------------------------------------------
    assign line = ~(hostLow | lineOe);
    // low pulse then high gap, changes made at the falling clock edge
    task automatic pulse(input int lo, input int hi);
        hostLow <= 1'b1;
        repeat (lo) @(negedge mclk);
        hostLow <= 1'b0;
        repeat (hi) @(negedge mclk);
    endtask : pulse
    // power-up wait, long low, then stable high before any bit
    task automatic wake(input int lo, input int hi);
        repeat (20) @(negedge mclk);
        pulse(lo, hi);
    endtask : wake
    // one bit: start pulse, a zero adds a low pulse after a high gap
    task automatic send_bit(input logic b, input int w, input int per);
        pulse(w, w);
        if (!b) pulse(w, w);
        repeat (per - (b ? 2 : 4) * w) @(negedge mclk);
    endtask : send_bit
endmodule : swl_host_model

/* dv/swl_link_tb.sv */
// Purpose: self-checking bench for the device end of the link
// Assumes: scaled counts; host model on the line
// Notes: inputs change at the falling edge of mclk
`timescale 1ns/100ps
module swl_link_tb;
    import swl_pkg::*;
    localparam int PW = 10, BW = 80, TW = 150, IW = 1000, WW = 3000;
    logic mclk = 1'b0, rst_n = 1'b0;
    logic txReq = 1'b0, txBit = 1'b0, txLast = 1'b0;
    logic line, lineOut, lineOe, rxValid, rxBit, txTaken, awake, busy;
    logic rxQ[$];
    int errCount = 0, checkCount = 0, cyc = 0, awakeLen = 0, n, txCount = 0;
    // ------------------------------------------------------------
    // clock, device and host
    // ------------------------------------------------------------
    always #2 mclk = ~mclk;
    swl_link #(.WDOG_CYC(64'd3000), .IDLE_CYC(64'd1000), .TURN_CYC(TW),
        .PULSE_CYC(PW), .BIT_CYC(BW), .WAKE_CYC(50), .SLP_FLT_CYC(20)) uut (
        .mclk(mclk), .rst_n(rst_n), .lineIn(line), .lineOut(lineOut),
        .lineOe(lineOe), .rxValid(rxValid), .rxBit(rxBit), .txReq(txReq),
        .txBit(txBit), .txLast(txLast), .txTaken(txTaken), .awake(awake),
        .busy(busy));
    swl_host_model host (.mclk(mclk), .lineOe(lineOe), .line(line));
    // collect received bits, time awake stints, cut a hang short
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (rxValid === 1'b1) rxQ.push_back(rxBit);
        if (awake === 1'b1) awakeLen <= awakeLen + 1;
        if (txTaken === 1'b1) txCount <= txCount + 1;
        if (cyc == 20000) begin
            errCount = errCount + 1;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // compare and wait helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %0h expected %0h", $time,
                got, exp);
        end
    endtask : check
    task automatic in_range(input int got, input int lo, input int hi);
        checkCount++;
        if (got < lo || got > hi) begin
            errCount++;
            $display("wrong value at %0t: got %0h expected %0h to %0h",
                $time, got, lo, hi);
        end
    endtask : in_range
    task automatic count_until(ref logic s, input logic v, output int k);
        k = 0;
        while (s !== v && k < 5000) begin
            @(negedge mclk);
            k++;
        end
        if (s !== v) errCount++; // waited too long
    endtask : count_until
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_sleep_wake();
        check(lineOe, 1'b0);
        check(busy, 1'b0);
        check(lineOut, 1'b0);
        host.pulse(15, 40);
        check(awake, 1'b0);
        host.wake(100, 100);
        check(awake, 1'b1);
        $display("test sleep_wake done");
    endtask : t_sleep_wake
    task automatic t_rx();
        rxQ.delete();
        host.send_bit(1'b0, 15, BW);
        host.send_bit(1'b1, 15, BW);
        host.pulse(5, BW);
        check(rxQ.size(), 2);
        check(rxQ[0], 1'b0);
        check(rxQ[1], 1'b1);
        $display("test rx done");
    endtask : t_rx
    task automatic t_tx();
        txReq <= 1'b1;
        host.pulse(15, 0);
        count_until(lineOe, 1'b1, n);
        in_range(n + 15, TW, TW + 25);
        check(busy, 1'b1);
        txBit <= 1'b1;
        txLast <= 1'b1;
        count_until(lineOe, 1'b0, n);
        check(n, PW);
        count_until(lineOe, 1'b1, n);
        check(n, PW);
        count_until(lineOe, 1'b0, n);
        check(n, PW);
        count_until(lineOe, 1'b1, n);
        check(n + 3 * PW, BW);
        txReq <= 1'b0;
        count_until(lineOe, 1'b0, n);
        check(n, PW);
        repeat (BW) @(negedge mclk);
        check(lineOe, 1'b0);
        check(busy, 1'b0);
        check(txCount, 2);
        $display("test tx done");
    endtask : t_tx
    task automatic t_idle();
        count_until(awake, 1'b0, n);
        in_range(n, IW - 180, IW + 25);
        $display("test idle done");
    endtask : t_idle
    task automatic t_watchdog();
        awakeLen = 0;
        host.wake(100, 100);
        for (int i = 0; i < 15 && awake === 1'b1; i++) begin
            host.send_bit(1'b1, 15, 300);
        end
        in_range(awakeLen, WW - 2, WW + 2);
        $display("test watchdog done");
    endtask : t_watchdog
    // ------------------------------------------------------------
    // verdict
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // main sequence
    initial begin
        repeat (4) @(negedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        t_sleep_wake();
        t_rx();
        t_tx();
        t_idle();
        t_watchdog();
        tally_and_finish();
    end
endmodule : swl_link_tb
